// ==== rtl/gauge_power_modes_current_report.v ====
// Power-mode sequencing and current reporting of a battery gauge, APB slave
//
// Functional notes
// - Active mode measures everything and watches undervoltage
// - Suspend and Sleep stop all measurement
// - Suspend entry: permit, long low, interval, quiet
// - Suspend period expiry wakes for one measurement
// - Quiet result resumes Suspend, else pin interrupt
// - Sleep entry: permit, long low, interval zero
// - Undervoltage for delay enters Sleep when enabled
// - Line rising edge returns to Active
// - Reset: Active, all power control bits clear
// - One current sample every 687 us
// - Current register: mean of 128 samples
// - Average register: mean of 4096 samples
// - Snapshot holds post-trigger sample until cleared
// - Averaging and accumulation continue during snapshot
// - Two's complement, positive means charge current
// - Out-of-range values saturate to 7FFF/8000
// - Threshold crossings raise alarm on chosen pin
// - Periodic automatic current offset correction
// - Nonzero interval picks period, disables alarm
// - Pin stays low until host writes one or Sleep is entered
`include "gauge_regs.vh"
`timescale 1ns/1ps
module gauge_power_modes_current_report #(
   parameter SAMPLE_CYC    = `SAMPLE_CYC,
   parameter LINE_LOW_CYC  = `LINE_LOW_CYC,
   parameter UV_DELAY_CYC  = `UV_DELAY_CYC,
   parameter SUS_SHORT_CYC = `SUS_SHORT_CYC,
   parameter SUS_MID_CYC   = `SUS_MID_CYC,
   parameter SUS_LONG_CYC  = `SUS_LONG_CYC
) (
   input  wire               mclk,
   input  wire               rst,
   input  wire               psel,
   input  wire               penable,
   input  wire               pwrite,
   input  wire        [7:0]  paddr,
   input  wire        [31:0] pwdata,
   output reg         [31:0] prdata,
   output wire               pready,
   output wire               pslverr,
   input  wire               line_in,
   output wire               line_out,
   output wire               line_oe,
   input  wire               gpio_in,
   output wire               gpio_out,
   output wire               gpio_oe,
   input  wire signed [16:0] adc_current,
   input  wire signed [16:0] adc_offset,
   input  wire               uv_below,
   input  wire signed [7:0]  temp_value,
   input  wire               snapshot_hold_trigger,
   output wire               meas_en,
   output wire               lp_osc_en
);
   // ****************************************
   // Declarations
   // ****************************************
   localparam ST_ACTIVE  = 4'b0001;
   localparam ST_SUSPEND = 4'b0010;
   localparam ST_SLEEP   = 4'b0100;
   localparam ST_WAKE    = 4'b1000;

   reg  [3:0]              state_q;
   reg  [3:0]              state_d;
   reg  [2:0]              line_sync_q;
   reg  [2:0]              gpio_sync_q;
   reg  [1:0]              uv_sync_q;
   reg  [31:0]             line_low_cnt_q;
   reg                     line_low_long_q;
   reg  [31:0]             uv_cnt_q;
   reg                     uv_timeout_q;
   reg  [31:0]             sus_cnt_q;
   reg  [31:0]             div_q;
   reg  [`OFFSET_LOG2N-1:0] ofs_cnt_q;
   reg  signed [16:0]      offset_q;
   reg  [`CTRL_W-1:0]      ctrl_q;
   reg                     pin_q;
   reg  [15:0]             cur_q;
   reg  [15:0]             acr_q;
   reg  [15:0]             sus_chg_q;
   reg  [15:0]             sus_dis_q;
   reg  [15:0]             temp_thr_q;
   reg  [15:0]             acr_thr_q;
   reg                     alarm_q;
   reg                     snapshot_hold_pend_q;
   reg  [31:0]             sus_len;
   reg  [16:0]             acr_sum;
   wire                    line_hi;
   wire                    line_rise;
   wire                    gpio_lvl;
   wire                    awake;
   wire                    sample_tick;
   wire signed [17:0]      diff;
   wire signed [16:0]      corr;
   wire [15:0]             corr16;
   wire                    quiet;
   wire                    quiet_now;
   wire                    permit;
   wire [1:0]              sis;
   wire                    alarm_hit;
   wire                    alarm_armed;
   wire                    cur_valid;
   wire [15:0]             cur_mean;
   wire                    avg_valid;
   wire [15:0]             avg_mean;
   wire                    wr;
   wire                    hit;
   wire [31:0]             status;

   // ****************************************
   // Input synchronisers and line edge
   // ****************************************
   // Pin levels pass two flops; the third stage only feeds edge detection
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         line_sync_q <= 3'b111;
         gpio_sync_q <= 3'b111;
         uv_sync_q   <= 2'b00;
      end else begin
         line_sync_q <= {line_sync_q[1:0], line_in};
         gpio_sync_q <= {gpio_sync_q[1:0], gpio_in};
         uv_sync_q   <= {uv_sync_q[0], uv_below};
      end
   end

   assign line_hi   = line_sync_q[1];
   assign line_rise = line_sync_q[1] & ~line_sync_q[2];
   assign gpio_lvl  = gpio_sync_q[1];
   assign awake     = state_q[0] | state_q[3];
   assign meas_en   = awake;
   assign lp_osc_en = state_q[1];
   assign permit    = ctrl_q[`CTRL_PERMIT];
   assign sis       = ctrl_q[`CTRL_SIS_HI:`CTRL_SIS_LO];

   // ****************************************
   // Timers
   // ****************************************
   // Line-low and undervoltage timers
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         line_low_cnt_q  <= 32'h0000_0000;
         line_low_long_q <= 1'b0;
         uv_cnt_q        <= 32'h0000_0000;
         uv_timeout_q    <= 1'b0;
      end else begin
         if (line_hi) begin
            line_low_cnt_q  <= 32'h0000_0000;
            line_low_long_q <= 1'b0;
         end else if (line_low_cnt_q == LINE_LOW_CYC) begin
            line_low_long_q <= 1'b1;
         end else begin
            line_low_cnt_q  <= line_low_cnt_q + 32'h0000_0001;
         end
         if (!awake || !uv_sync_q[1]) begin
            uv_cnt_q     <= 32'h0000_0000;
            uv_timeout_q <= 1'b0;
         end else if (uv_cnt_q == UV_DELAY_CYC) begin
            uv_timeout_q <= 1'b1;
         end else begin
            uv_cnt_q     <= uv_cnt_q + 32'h0000_0001;
         end
      end
   end

   // Suspend period chosen by the interval select
   always @* begin
      case (sis)
         `SIS_SHORT: sus_len = SUS_SHORT_CYC;
         `SIS_MID:   sus_len = SUS_MID_CYC;
         default:    sus_len = SUS_LONG_CYC;
      endcase
   end

   // Sample divider and suspend counter
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_q     <= 32'h0000_0000;
         sus_cnt_q <= 32'h0000_0000;
      end else begin
         if (!awake || sample_tick)
            div_q <= 32'h0000_0000;
         else
            div_q <= div_q + 32'h0000_0001;
         if (state_q != ST_SUSPEND)
            sus_cnt_q <= 32'h0000_0000;
         else
            sus_cnt_q <= sus_cnt_q + 32'h0000_0001;
      end
   end

   assign sample_tick = awake && (div_q == SAMPLE_CYC - 1);

   // ****************************************
   // Sample conditioning
   // ****************************************
   // Offset-corrected sample, clamped twice
   assign diff   = {adc_current[16], adc_current} - {offset_q[16], offset_q};
   assign corr   = (diff[17] != diff[16]) ? {diff[17], {16{~diff[17]}}} : diff[16:0];
   assign corr16 = (corr[16] != corr[15]) ?
                   (corr[16] ? `SAT_NEG : `SAT_POS) : corr[15:0];
   assign quiet     = ($signed(cur_q) < $signed(sus_chg_q)) &&
                      ($signed(cur_q) > $signed(sus_dis_q));
   assign quiet_now = ($signed(corr16) < $signed(sus_chg_q)) &&
                      ($signed(corr16) > $signed(sus_dis_q));

   // Offset reference refreshed every block of samples while awake
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ofs_cnt_q <= {`OFFSET_LOG2N{1'b0}};
         offset_q  <= 17'h0_0000;
      end else if (sample_tick) begin
         ofs_cnt_q <= ofs_cnt_q + 1'b1;
         if (&ofs_cnt_q)
            offset_q <= adc_offset;
      end
   end

   // ****************************************
   // Averagers
   // ****************************************
   sample_averager #(
      .LOG2N        (`CUR_LOG2N)
   ) u_cur_avg (
      .mclk         (mclk),
      .rst          (rst),
      .sample_valid (sample_tick),
      .sample       (corr),
      .mean_valid   (cur_valid),
      .mean         (cur_mean)
   );

   sample_averager #(
      .LOG2N        (`AVG_LOG2N)
   ) u_avg_avg (
      .mclk         (mclk),
      .rst          (rst),
      .sample_valid (sample_tick),
      .sample       (corr),
      .mean_valid   (avg_valid),
      .mean         (avg_mean)
   );

   // ****************************************
   // Power mode state machine
   // ****************************************
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_ACTIVE: begin
            if (permit && ctrl_q[`CTRL_UNDERVOLTAGE_SLEEP_ENABLE] && uv_timeout_q)
               state_d = ST_SLEEP;
            else if (permit && line_low_long_q && sis == `SIS_OFF)
               state_d = ST_SLEEP;
            else if (permit && line_low_long_q && quiet && pin_q)
               state_d = ST_SUSPEND;
         end
         ST_SUSPEND: begin
            if (line_rise)
               state_d = ST_ACTIVE;
            else if (sus_cnt_q >= sus_len - 1)
               state_d = ST_WAKE;
         end
         ST_SLEEP: begin
            if (line_rise)
               state_d = ST_ACTIVE;
         end
         ST_WAKE: begin
            if (line_rise)
               state_d = ST_ACTIVE;
            else if (permit && ctrl_q[`CTRL_UNDERVOLTAGE_SLEEP_ENABLE] && uv_timeout_q)
               state_d = ST_SLEEP;
            else if (sample_tick)
               state_d = quiet_now ? ST_SUSPEND : ST_ACTIVE;
         end
         default: state_d = ST_ACTIVE;
      endcase
   end

   always @(posedge mclk or posedge rst) begin
      if (rst)
         state_q <= ST_ACTIVE;
      else
         state_q <= state_d;
   end

   // ****************************************
   // Alarm comparator
   // ****************************************
   // Temperature or accumulator outside limits
   assign alarm_armed = ctrl_q[`CTRL_ALM_EN] && (sis == `SIS_OFF);
   assign alarm_hit   = alarm_armed && awake &&
                        (($signed(temp_value) > $signed(temp_thr_q[15:8])) ||
                         ($signed(temp_value) < $signed(temp_thr_q[7:0])) ||
                         ($signed(acr_q[15:8]) > $signed(acr_thr_q[15:8])) ||
                         ($signed(acr_q[15:8]) < $signed(acr_thr_q[7:0])));

   // ****************************************
   // APB slave and registers
   // ****************************************
   assign pready  = 1'b1;
   assign wr      = psel && penable && pwrite;
   assign hit     = (paddr == `OFF_CTRL)    || (paddr == `OFF_SFR)     ||
                    (paddr == `OFF_CUR)     || (paddr == `OFF_AVG)     ||
                    (paddr == `OFF_ACR)     || (paddr == `OFF_SUS_CHG) ||
                    (paddr == `OFF_SUS_DIS) || (paddr == `OFF_TEMP_THR) ||
                    (paddr == `OFF_ACR_THR) || (paddr == `OFF_STATUS);
   assign pslverr = psel && penable && !hit;
   assign status  = {25'h000_0000, uv_sync_q[1], line_low_long_q, alarm_q, state_q};

   // Saturating accumulation of the upper bits of each sample
   always @* begin
      acr_sum = {acr_q[15], acr_q} + {{5{corr[16]}}, corr[16:5]};
      if (acr_sum[16] != acr_sum[15])
         acr_sum = {acr_sum[16], acr_sum[16] ? `SAT_NEG : `SAT_POS};
   end

   // Register file; hardware set of a flag wins over a software clear
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q      <= `CTRL_RST;
         pin_q       <= `SFR_PIN_RST;
         cur_q       <= `CUR_RST;
         acr_q       <= `ACR_RST;
         sus_chg_q   <= `THR_RST;
         sus_dis_q   <= `THR_RST;
         temp_thr_q  <= `THR_RST;
         acr_thr_q   <= `THR_RST;
         alarm_q     <= 1'b0;
         snapshot_hold_pend_q <= 1'b0;
      end else begin
         if (wr && paddr == `OFF_CTRL)
            ctrl_q <= pwdata[`CTRL_W-1:0];
         if (wr && paddr == `OFF_SFR)
            pin_q <= pwdata[`SFR_PIN];
         if (wr && paddr == `OFF_SUS_CHG)
            sus_chg_q <= pwdata[15:0];
         if (wr && paddr == `OFF_SUS_DIS)
            sus_dis_q <= pwdata[15:0];
         if (wr && paddr == `OFF_TEMP_THR)
            temp_thr_q <= pwdata[15:0];
         if (wr && paddr == `OFF_ACR_THR)
            acr_thr_q <= pwdata[15:0];
         if (wr && paddr == `OFF_STATUS && pwdata[`STAT_ALARM])
            alarm_q <= 1'b0;
         if (alarm_hit)
            alarm_q <= 1'b1;
         // Wake result outside the window pulls the pin bit low
         if (state_q == ST_WAKE && sample_tick && !quiet_now && !line_rise)
            pin_q <= 1'b0;
         if (state_q == ST_SLEEP)
            pin_q <= 1'b1;
         if (sample_tick)
            acr_q <= acr_sum[15:0];
         if (wr && paddr == `OFF_ACR)
            acr_q <= pwdata[15:0];
         // Snapshot: next sample after the trigger is held until cleared
         if (snapshot_hold_trigger)
            snapshot_hold_pend_q <= 1'b1;
         if (snapshot_hold_pend_q && sample_tick) begin
            snapshot_hold_pend_q          <= 1'b0;
            cur_q                <= corr16;
            ctrl_q[`CTRL_SNAPSHOT_HOLD]   <= 1'b1;
         end else if (cur_valid && !ctrl_q[`CTRL_SNAPSHOT_HOLD] && !snapshot_hold_pend_q) begin
            cur_q <= cur_mean;
         end
      end
   end

   // Average register, loaded on its own
   reg [15:0] avg_q;
   always @(posedge mclk or posedge rst) begin
      if (rst)
         avg_q <= `CUR_RST;
      else if (avg_valid)
         avg_q <= avg_mean;
   end

   // Read data mux
   always @* begin
      case (paddr)
         `OFF_CTRL:     prdata = {25'h000_0000, ctrl_q};
         `OFF_SFR:      prdata = {30'h0000_0000, gpio_lvl, pin_q};
         `OFF_CUR:      prdata = {{16{cur_q[15]}}, cur_q};
         `OFF_AVG:      prdata = {{16{avg_q[15]}}, avg_q};
         `OFF_ACR:      prdata = {16'h0000, acr_q};
         `OFF_SUS_CHG:  prdata = {16'h0000, sus_chg_q};
         `OFF_SUS_DIS:  prdata = {16'h0000, sus_dis_q};
         `OFF_TEMP_THR: prdata = {16'h0000, temp_thr_q};
         `OFF_ACR_THR:  prdata = {16'h0000, acr_thr_q};
         `OFF_STATUS:   prdata = status;
         default:       prdata = 32'h0000_0000;
      endcase
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   // Open-drain pins pull low only while awake
   assign gpio_out = 1'b0;
   assign gpio_oe  = awake && (!pin_q ||
                     (alarm_q && alarm_armed && !ctrl_q[`CTRL_ALM_DQ]));
   assign line_out = 1'b0;
   assign line_oe  = awake && alarm_q && alarm_armed && ctrl_q[`CTRL_ALM_DQ];

endmodule // gauge_power_modes_current_report

// ==== rtl/gauge_regs.vh ====
// Register map, fields and timing figures of the gauge block
`ifndef GAUGE_REGS_VH
`define GAUGE_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_CTRL       8'h00
`define OFF_SFR        8'h04
`define OFF_CUR        8'h08
`define OFF_AVG        8'h0c
`define OFF_ACR        8'h10
`define OFF_SUS_CHG    8'h14
`define OFF_SUS_DIS    8'h18
`define OFF_TEMP_THR   8'h1c
`define OFF_ACR_THR    8'h20
`define OFF_STATUS     8'h24

// ****************************************
// Control register fields
// ****************************************
`define CTRL_PERMIT    0
`define CTRL_UNDERVOLTAGE_SLEEP_ENABLE      1
`define CTRL_SIS_LO    2
`define CTRL_SIS_HI    3
`define CTRL_SNAPSHOT_HOLD      4
`define CTRL_ALM_EN    5
`define CTRL_ALM_DQ    6
`define CTRL_W         7
`define CTRL_RST       7'h00

// ****************************************
// Special feature register and status fields
// ****************************************
`define SFR_PIN        0
`define SFR_LEVEL      1
`define SFR_PIN_RST    1'b1
`define STAT_ALARM     4
`define STAT_LINE_LONG 5
`define STAT_UV        6
`define THR_RST        16'h0000
`define ACR_RST        16'h0000
`define CUR_RST        16'h0000
`define SAT_POS        16'h7fff
`define SAT_NEG        16'h8000
`define SIS_OFF        2'b00
`define SIS_SHORT      2'b01
`define SIS_MID        2'b10

// ****************************************
// Timing figures and derived cycle counts
// ****************************************
`define CLK_PERIOD_NS      4
`define CYC_PER_US         (1000 / `CLK_PERIOD_NS)
`define CYC_PER_MS         (1000000 / `CLK_PERIOD_NS)
`define SAMPLE_PERIOD_US   687
`define SAMPLE_CYC         (`SAMPLE_PERIOD_US * `CYC_PER_US)
`define LINE_LOW_SLEEP_MS  2100
`define LINE_LOW_CYC       (`LINE_LOW_SLEEP_MS * `CYC_PER_MS)
`define UV_DELAY_MS        82
`define UV_DELAY_CYC       (`UV_DELAY_MS * `CYC_PER_MS)
`define SUS_SHORT_MS       1000
`define SUS_MID_MS         2000
`define SUS_LONG_MS        4000
`define SUS_SHORT_CYC      (`SUS_SHORT_MS * `CYC_PER_MS)
`define SUS_MID_CYC        (`SUS_MID_MS * `CYC_PER_MS)
`define SUS_LONG_CYC       (`SUS_LONG_MS * `CYC_PER_MS)
`define CUR_LOG2N          7
`define AVG_LOG2N          12
`define OFFSET_LOG2N       8

`endif

// ==== rtl/sample_averager.v ====
// Block averager: sums 2**LOG2N samples and posts the saturated mean
`include "gauge_regs.vh"
`timescale 1ns/1ps
module sample_averager #(
   parameter LOG2N = 7
) (
   input  wire               mclk,
   input  wire               rst,
   input  wire               sample_valid,
   input  wire signed [16:0] sample,
   output reg                mean_valid,
   output reg         [15:0] mean
);
   reg  [16+LOG2N:0] sum_q;
   reg  [LOG2N-1:0]  cnt_q;
   wire [16+LOG2N:0] total;
   wire [16:0]       avg;

   // Running sum with the new sample sign extended
   assign total = sum_q + {{LOG2N{sample[16]}}, sample};
   assign avg   = total[16+LOG2N:LOG2N];

   // Accumulate; on the last sample post the mean, clamped to 16 bits
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         sum_q      <= {(17+LOG2N){1'b0}};
         cnt_q      <= {LOG2N{1'b0}};
         mean_valid <= 1'b0;
         mean       <= `CUR_RST;
      end else begin
         mean_valid <= 1'b0;
         if (sample_valid) begin
            cnt_q <= cnt_q + 1'b1;
            if (&cnt_q) begin
               sum_q      <= {(17+LOG2N){1'b0}};
               mean_valid <= 1'b1;
               if (avg[16] != avg[15])
                  mean <= avg[16] ? `SAT_NEG : `SAT_POS;
               else
                  mean <= avg[15:0];
            end else begin
               sum_q <= total;
            end
         end
      end
   end
endmodule // sample_averager

// ==== testbench/gauge_monitor.sv ====
// Assertions on the gauge block's ports
`timescale 1ns/1ps
module gauge_monitor #(
   parameter LINE_LOW_CYC  = 50,
   parameter SUS_SHORT_CYC = 100,
   parameter SUS_LONG_CYC  = 300
) (
   input wire        mclk,
   input wire        rst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pslverr,
   input wire        line_in,
   input wire        gpio_oe,
   input wire        meas_en,
   input wire        lp_osc_en
);
   // ************
   // Helper counters
   // ************
   logic [31:0] low_q;
   logic [31:0] sus_q;
   wire         acc = psel && penable;
   // Line-low and suspend stretch lengths
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         low_q <= 32'h0000_0000;
         sus_q <= 32'h0000_0000;
      end else begin
         low_q <= line_in ? 32'h0000_0000 : low_q + 32'h0000_0001;
         sus_q <= lp_osc_en ? sus_q + 32'h0000_0001 : 32'h0000_0000;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ************
   // Properties
   // ************
   property p_rst_state; $fell(rst) |-> meas_en && !lp_osc_en && !gpio_oe; endproperty
   a_rst_state: assert property (p_rst_state) else $error("reset state");
   property p_no_meas; lp_osc_en |-> !meas_en; endproperty
   a_no_meas: assert property (p_no_meas) else $error("measuring in suspend");
   property p_entry; $rose(lp_osc_en) |-> $past(low_q, 3) >= LINE_LOW_CYC - 4; endproperty
   a_entry: assert property (p_entry) else $error("early suspend entry");
   property p_early; $fell(lp_osc_en) |-> sus_q >= SUS_SHORT_CYC - 4 || line_in; endproperty
   a_early: assert property (p_early) else $error("early wake");
   property p_late; lp_osc_en |-> sus_q <= SUS_LONG_CYC + 4; endproperty
   a_late: assert property (p_late) else $error("late wake");
   property p_wake; $rose(line_in) |-> ##[1:6] meas_en; endproperty
   a_wake: assert property (p_wake) else $error("no wake on line rise");
   property p_irq; $rose(gpio_oe) |-> meas_en && !lp_osc_en; endproperty
   a_irq: assert property (p_irq) else $error("pin while asleep");
   property p_hold;
      $fell(gpio_oe) |-> $past(acc && pwrite && paddr == 8'h04 && pwdata[0]) || !meas_en
         || !line_in;
   endproperty
   a_hold: assert property (p_hold) else $error("pin released early");
   property p_sext;
      acc && !pwrite && (paddr == 8'h08 || paddr == 8'h0c) |-> prdata[31:16] == {16{prdata[15]}};
   endproperty
   a_sext: assert property (p_sext) else $error("no sign extension");
   property p_unmap; acc && paddr > 8'h24 |-> pslverr && prdata == 32'h0000_0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped accepted");
endmodule // gauge_monitor

bind gauge_power_modes_current_report gauge_monitor #(.LINE_LOW_CYC(LINE_LOW_CYC),
   .SUS_SHORT_CYC(SUS_SHORT_CYC), .SUS_LONG_CYC(SUS_LONG_CYC)) u_mon (.mclk(mclk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pslverr(pslverr), .line_in(line_in), .gpio_oe(gpio_oe),
   .meas_en(meas_en), .lp_osc_en(lp_osc_en));

// ==== testbench/host_line_model.sv ====
// Host line and pin model with pull-ups
`timescale 1ns/1ps
module host_line_model (
   input  wire  hold_low,
   input  wire  line_oe,
   input  wire  gpio_oe,
   output logic line_in,
   output logic gpio_in
);
   // Pulled up; host wakes the device by releasing it
   assign line_in = !(hold_low || line_oe);
   // Pulled up unless the device sinks it
   assign gpio_in = !gpio_oe;
endmodule // host_line_model

// ==== testbench/testbench.sv ====
// Self-checking gauge bench
`include "gauge_regs.vh"
`timescale 1ns/1ps
module testbench;
   localparam SC  = 20;
   localparam WIN = 2 * 128 * SC + 100;
   logic               mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
   logic [7:0]         paddr = 0;
   logic [31:0]        pwdata = 0, rd;
   logic               hold_low = 0, uv_below = 0, snapshot_hold_trigger = 0;
   logic signed [16:0] adc_current = 0, adc_offset = 0;
   logic signed [7:0]  temp_value = 0;
   wire  [31:0]        prdata;
   wire                pready, pslverr, line_in, line_oe, gpio_in, gpio_oe, meas_en, lp_osc_en;
   integer             seed = 32'h0000_7434, n_fail = 0, checked = 0;
   int                 vals[3] = '{0, 32'h0000_ffff, 32'hffff_0000};
   always #2 mclk = ~mclk;
   gauge_power_modes_current_report #(.SAMPLE_CYC(SC), .LINE_LOW_CYC(50), .UV_DELAY_CYC(30),
      .SUS_SHORT_CYC(100), .SUS_MID_CYC(200), .SUS_LONG_CYC(300)) dut (.mclk(mclk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in), .line_out(),
      .line_oe(line_oe), .gpio_in(gpio_in), .gpio_out(), .gpio_oe(gpio_oe),
      .adc_current(adc_current), .adc_offset(adc_offset), .uv_below(uv_below),
      .temp_value(temp_value), .snapshot_hold_trigger(snapshot_hold_trigger), .meas_en(meas_en),
      .lp_osc_en(lp_osc_en));
   host_line_model u_host (.hold_low(hold_low), .line_oe(line_oe), .gpio_oe(gpio_oe),
      .line_in(line_in), .gpio_in(gpio_in));
   // ************
   // Bench tasks
   // ************
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64) n_fail++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic waitfor(input int s, input logic v, input int lim);
      int n;
      n = 0;
      while ((s == 0 ? meas_en : s == 1 ? lp_osc_en : gpio_oe) !== v && n < lim) begin
         @(posedge mclk);
         n++;
      end
   endtask
   // Expected word: clamp, sign extend
   function automatic logic [31:0] sat16(input int v);
      if (v > 32767) v = 32767;
      if (v < -32768) v = -32768;
      return 32'(v);
   endfunction
   task summarize;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ************
   // Main sequence
   // ************
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, `OFF_CTRL, 32'h0000_0000);
      chk("ctrl reset", rd, 32'h0000_0000);
      apb(1'b0, `OFF_STATUS, 32'h0000_0000);
      chk("state reset", rd[3:0], 4'h1);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
      vals[0] = $random(seed) % 2000;
      foreach (vals[i]) begin
         adc_current <= 17'(vals[i]);
         temp_value <= 8'($random(seed));
         repeat (WIN) @(posedge mclk);
         apb(1'b0, `OFF_CUR, 32'h0000_0000);
         chk("current", rd, sat16(vals[i]));
      end
      // One snapshot only
      adc_current <= 17'h0_0309;
      snapshot_hold_trigger <= 1'b1;
      @(posedge mclk);
      snapshot_hold_trigger <= 1'b0;
      repeat (SC + 2) @(posedge mclk);
      adc_current <= 17'h0_0000;
      repeat (WIN) @(posedge mclk);
      apb(1'b0, `OFF_CUR, 32'h0000_0000);
      chk("snapshot_hold held", rd, 32'h0000_0309);
      apb(1'b0, `OFF_CTRL, 32'h0000_0000);
      chk("snapshot_hold bit", rd[4], 1'b1);
      apb(1'b1, `OFF_CTRL, 32'h0000_0000);
      repeat (WIN) @(posedge mclk);
      apb(1'b0, `OFF_CUR, 32'h0000_0000);
      chk("snapshot_hold clear", rd, 32'h0000_0000);
      apb(1'b1, `OFF_CTRL, 32'h0000_0001);
      hold_low <= 1'b1;
      repeat (40) @(posedge mclk);
      hold_low <= 1'b0;
      repeat (5) @(posedge mclk);
      hold_low <= 1'b1;
      repeat (40) @(posedge mclk);
      chk("timer restart", meas_en, 1'b1);
      waitfor(0, 1'b0, 100);
      chk("sleep", {lp_osc_en, meas_en}, 2'b00);
      apb(1'b0, `OFF_STATUS, 32'h0000_0000);
      chk("sleep state", rd[3:0], 4'h4);
      hold_low <= 1'b0;
      waitfor(0, 1'b1, 8);
      chk("line wake", meas_en, 1'b1);
      apb(1'b1, `OFF_SUS_CHG, 32'h0000_0064);
      apb(1'b1, `OFF_SUS_DIS, 32'hffff_ff9c);
      apb(1'b1, `OFF_CTRL, 32'h0000_0005);
      hold_low <= 1'b1;
      waitfor(1, 1'b1, 100);
      chk("suspend", {lp_osc_en, meas_en}, 2'b10);
      waitfor(0, 1'b1, 150);
      chk("period wake", meas_en, 1'b1);
      waitfor(1, 1'b1, 40);
      chk("resuspend", lp_osc_en, 1'b1);
      adc_current <= 17'h0_01f4;
      waitfor(2, 1'b1, 200);
      chk("irq", {gpio_oe, meas_en, lp_osc_en}, 3'b110);
      apb(1'b0, `OFF_SFR, 32'h0000_0000);
      chk("pin bit", rd[0], 1'b0);
      repeat (20) @(posedge mclk);
      chk("pin held", gpio_oe, 1'b1);
      apb(1'b1, `OFF_SFR, 32'h0000_0001);
      @(posedge mclk);
      chk("pin freed", gpio_oe, 1'b0);
      hold_low <= 1'b0;
      apb(1'b1, `OFF_CTRL, 32'h0000_0003);
      uv_below <= 1'b1;
      repeat (20) @(posedge mclk);
      uv_below <= 1'b0;
      repeat (10) @(posedge mclk);
      chk("uv short", meas_en, 1'b1);
      uv_below <= 1'b1;
      waitfor(0, 1'b0, 60);
      chk("uv sleep", {meas_en, lp_osc_en}, 2'b00);
      uv_below <= 1'b0;
      hold_low <= 1'b1;
      repeat (5) @(posedge mclk);
      hold_low <= 1'b0;
      waitfor(0, 1'b1, 8);
      chk("uv wake", meas_en, 1'b1);
      summarize();
   end
   // Hang guard
   initial begin
      #(4 * 60000);
      n_fail++;
      summarize();
   end
endmodule // testbench
